// >>> hw/csp_pkg.sv
// Purpose: Constants and types for the clocked serial port output phasing block
// Assumes: Single core clock at 125 MHz, registers over a plain strobe port
// Notes:   Register offsets are 4-bit addresses of 8-bit registers
// Notes on behaviour
// - Four clock/data phase types supported
// - Phase 0: first bit latched on launch edge
// - Phase 0: opposite edge loads, shifts, captures
// - Phase 0: later bits launched each launch edge
// - Phase 1: first bit shown at start
// - Phase 1: first edge loads, shifts, captures
// - Phase 1: later bits on opposite edges
// - Mode 1: output holds last bit after transfer
// - Disabled, mode 1, phase 1: buffer end bit
// - Select writes update output at once
// - Pin level follows direction and latch
// - Eight bits per transfer, clock synchronised
// - Active flag set, cleared; done raised
// - Disable clears active flag and shifter
package csp_pkg;
   localparam logic [3:0] CSP_ADDR_MODE   = 4'h0;
   localparam logic [3:0] CSP_ADDR_CLKSEL = 4'h4;
   localparam logic [3:0] CSP_ADDR_TXBUF  = 4'h8;
   localparam logic [3:0] CSP_ADDR_SHIFT  = 4'hC;
   localparam logic [3:0] CSP_ADDR_IRQST  = 4'h1;
   localparam logic [3:0] CSP_ADDR_IRQMSK = 4'h2;
   localparam logic [3:0] CSP_ADDR_PORT   = 4'h3;
   // Mode register fields
   localparam int CSP_MODE_EN_BIT    = 7;
   localparam int CSP_MODE_TRMD_BIT  = 6;
   localparam int CSP_MODE_DIR_BIT   = 4;
   localparam int CSP_MODE_ACT_BIT   = 0;
   // Clock select register fields
   localparam int CSP_CLK_CKP_BIT    = 4;
   localparam int CSP_CLK_DAP_BIT    = 3;
   // Port control register fields
   localparam int CSP_PORT_DIR_BIT   = 1;
   localparam int CSP_PORT_LAT_BIT   = 0;
   localparam logic [7:0] CSP_MODE_RST   = 8'h00;
   localparam logic [7:0] CSP_CLKSEL_RST = 8'h00;
   localparam logic [1:0] CSP_PORT_RST   = 2'h1;
   localparam logic [3:0] CSP_BITS       = 4'h8;
   localparam int CSP_SYNC_STAGES = 2;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } csp_bus_req_type;
   typedef struct packed {
      logic en;
      logic trmd;
      logic dir;
      logic ckp;
      logic dap;
   } csp_cfg_type;
   typedef enum logic [1:0] {
      CSP_IDLE  = 2'b00,
      CSP_FIRST = 2'b01,
      CSP_RUN   = 2'b10
   } csp_state_type;
endpackage : csp_pkg

// >>> hw/csp_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to clock_i
// Notes:   First stage read only by the second stage
`timescale 1ns/1ps
module csp_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // Data
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end
   assign q_o = q_r;
endmodule : csp_sync

// >>> hw/csp_top.sv
// Purpose: Slave clocked serial port: bit phasing, shifter, flags, interrupt
// Assumes: Serial clock and input come from the partner, sampled by clock_i
// Notes:   Serial clock pin is sampled, not used as a clock
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module csp_top (
   // Clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 rst_n_i,
   // Register port
   input  wire csp_pkg::csp_bus_req_type bus_i,
   output logic [7:0]                rdata_o,
   // Serial pins
   input  wire logic                 serial_clock_pin_i,
   input  wire logic                 serial_in_pin_i,
   output logic                      serial_out_pin_o,
   output logic                      serial_out_pin_oe_o,
   // Interrupt
   output logic                      irq_o
);
   import csp_pkg::*;

   logic rst_a_r, rst_b_r;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_a_r <= 1'b0;
         rst_b_r <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_b_r <= rst_a_r;
      end
   end
   logic rst_n;
   assign rst_n = rst_b_r;

   logic [1:0] pins_s;
   csp_sync #(.WIDTH(2)) u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n),
      .d_i     ({serial_clock_pin_i, serial_in_pin_i}),
      .q_o     (pins_s)
   );
   logic sck_s, sin_s, sck_d_r;
   assign sck_s = pins_s[1];
   assign sin_s = pins_s[0];

   // Registers
   csp_cfg_type   cfg_r, cfg_nxt;
   logic [7:0]    txbuf_r, txbuf_nxt;
   logic [7:0]    shift_r, shift_nxt;
   logic [7:0]    rdata_r, rdata_nxt;
   logic          lat_r, lat_nxt;
   logic          act_r, act_nxt;
   logic [3:0]    cnt_r, cnt_nxt;
   csp_state_type st_r, st_nxt;
   logic          done_r, done_nxt;
   logic          msk_r, msk_nxt;
   logic [1:0]    port_r, port_nxt;
   logic          so_r, so_nxt;
   logic          oe_r, oe_nxt;
   logic          irq_r, irq_nxt;

   function automatic logic end_bit(input logic [7:0] v, input logic lsb_first);
      end_bit = lsb_first ? v[0] : v[7];
   endfunction : end_bit

   function automatic logic [7:0] shl(input logic [7:0] v, input logic lsb_first,
                                      input logic in_bit);
      shl = lsb_first ? {in_bit, v[7:1]} : {v[6:0], in_bit};
   endfunction : shl

   // Idle level of the clock is ckp; lead edge leaves idle, trail returns; dap set makes trail the launch edge
   logic sck_n, sck_nd, edge_lead, edge_trail, edge_launch, edge_cap;
   assign sck_n      = sck_s ^ cfg_r.ckp;
   assign sck_nd     = sck_d_r ^ cfg_r.ckp;
   assign edge_lead  = sck_n & ~sck_nd;
   assign edge_trail = ~sck_n & sck_nd;
   assign edge_cap   = cfg_r.dap ? edge_lead : edge_trail;
   assign edge_launch = cfg_r.dap ? edge_trail : edge_lead;

   logic wr_mode, wr_clk, wr_tx, rd_shift, rd_irq, start;
   always_comb begin
      wr_mode  = 1'b0;
      wr_clk   = 1'b0;
      wr_tx    = 1'b0;
      rd_shift = 1'b0;
      rd_irq   = 1'b0;
      if (bus_i.wr && bus_i.addr == CSP_ADDR_MODE) begin
         wr_mode = 1'b1;
      end else if (bus_i.wr && bus_i.addr == CSP_ADDR_CLKSEL) begin
         wr_clk = 1'b1;
      end else if (bus_i.wr && bus_i.addr == CSP_ADDR_TXBUF) begin
         wr_tx = 1'b1;
      end else if (bus_i.rd && bus_i.addr == CSP_ADDR_SHIFT) begin
         rd_shift = 1'b1;
      end else if (bus_i.rd && bus_i.addr == CSP_ADDR_IRQST) begin
         rd_irq = 1'b1;
      end
      start = cfg_r.en && !act_r && ((wr_tx && cfg_r.trmd) || (rd_shift && !cfg_r.trmd));
   end

   // Register writes and reads
   always_comb begin
      cfg_nxt   = cfg_r;
      txbuf_nxt = txbuf_r;
      msk_nxt   = msk_r;
      port_nxt  = port_r;
      rdata_nxt = 8'h00;
      if (wr_mode) begin
         cfg_nxt.en   = bus_i.wdata[CSP_MODE_EN_BIT];
         cfg_nxt.trmd = bus_i.wdata[CSP_MODE_TRMD_BIT];
         cfg_nxt.dir  = bus_i.wdata[CSP_MODE_DIR_BIT];
      end
      if (wr_clk) begin
         cfg_nxt.ckp = bus_i.wdata[CSP_CLK_CKP_BIT];
         cfg_nxt.dap = bus_i.wdata[CSP_CLK_DAP_BIT];
      end
      if (wr_tx) begin
         txbuf_nxt = bus_i.wdata;
      end
      if (bus_i.wr && bus_i.addr == CSP_ADDR_IRQMSK) begin
         msk_nxt = bus_i.wdata[0];
      end
      if (bus_i.wr && bus_i.addr == CSP_ADDR_PORT) begin
         port_nxt = bus_i.wdata[1:0];
      end
      if (bus_i.rd) begin
         if (bus_i.addr == CSP_ADDR_MODE) begin
            rdata_nxt = {cfg_r.en, cfg_r.trmd, 1'b0, cfg_r.dir, 3'h0, act_r};
         end else if (bus_i.addr == CSP_ADDR_CLKSEL) begin
            rdata_nxt = {3'h0, cfg_r.ckp, cfg_r.dap, 3'h0};
         end else if (bus_i.addr == CSP_ADDR_TXBUF) begin
            rdata_nxt = txbuf_r;
         end else if (bus_i.addr == CSP_ADDR_SHIFT) begin
            rdata_nxt = shift_r;
         end else if (bus_i.addr == CSP_ADDR_IRQST) begin
            rdata_nxt = {7'h00, done_r};
         end else if (bus_i.addr == CSP_ADDR_IRQMSK) begin
            rdata_nxt = {7'h00, msk_r};
         end else if (bus_i.addr == CSP_ADDR_PORT) begin
            rdata_nxt = {6'h00, port_r};
         end
      end
   end

   // Transfer engine
   logic done_ev;
   always_comb begin
      st_nxt    = st_r;
      shift_nxt = shift_r;
      lat_nxt   = lat_r;
      act_nxt   = act_r;
      cnt_nxt   = cnt_r;
      done_ev   = 1'b0;
      case (st_r)
         CSP_IDLE: begin
            if (start) begin
               act_nxt = 1'b1;
               cnt_nxt = 4'h0;
               st_nxt  = CSP_FIRST;
               if (cfg_r.dap) begin
                  lat_nxt = end_bit(txbuf_nxt, cfg_r.dir);
               end
            end
         end
         CSP_FIRST: begin
            if (!cfg_r.dap && edge_launch) begin
               lat_nxt = end_bit(txbuf_r, cfg_r.dir);
            end else if (edge_cap) begin
               shift_nxt = shl(txbuf_r, cfg_r.dir, sin_s);
               cnt_nxt   = 4'h1;
               st_nxt    = CSP_RUN;
            end
         end
         CSP_RUN: begin
            if (edge_launch && cnt_r != CSP_BITS) begin
               lat_nxt = end_bit(shift_r, cfg_r.dir);
            end else if (edge_cap) begin
               shift_nxt = shl(shift_r, cfg_r.dir, sin_s);
               cnt_nxt   = cnt_r + 4'h1;
               if (cnt_r + 4'h1 == CSP_BITS) begin
                  act_nxt = 1'b0;
                  done_ev = 1'b1;
                  st_nxt  = CSP_IDLE;
               end
            end
         end
         default: st_nxt = CSP_IDLE;
      endcase
      if (!cfg_nxt.en) begin
         act_nxt   = 1'b0;
         shift_nxt = 8'h00;
         st_nxt    = CSP_IDLE;
         // Disabling is a mode change: the latch drops its last bit
         lat_nxt   = 1'b0;
      end
   end

   // Output selector, interrupt
   logic so_sel;
   always_comb begin
      if (!cfg_nxt.trmd) begin
         so_sel = 1'b0;
      end else if (!cfg_nxt.en && cfg_nxt.dap) begin
         so_sel = end_bit(txbuf_nxt, cfg_nxt.dir);
      end else begin
         so_sel = lat_nxt;
      end
      // Latch low: serial output reaches the pin; latch high: port level unless transmitting
      so_nxt   = port_nxt[CSP_PORT_LAT_BIT] ? !(cfg_nxt.en && cfg_nxt.trmd)
                                            : so_sel;
      oe_nxt   = ~port_nxt[CSP_PORT_DIR_BIT];
      done_nxt = done_ev | (done_r & ~rd_irq);
      irq_nxt  = done_nxt & msk_nxt;
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r   <= '0;
         txbuf_r <= 8'h00;
         shift_r <= 8'h00;
         rdata_r <= 8'h00;
         lat_r   <= 1'b0;
         act_r   <= 1'b0;
         cnt_r   <= 4'h0;
         st_r    <= CSP_IDLE;
         done_r  <= 1'b0;
         msk_r   <= 1'b0;
         port_r  <= CSP_PORT_RST;
         so_r    <= 1'b0;
         oe_r    <= 1'b0;
         irq_r   <= 1'b0;
         sck_d_r <= 1'b0;
      end else begin
         cfg_r   <= cfg_nxt;
         txbuf_r <= txbuf_nxt;
         shift_r <= shift_nxt;
         rdata_r <= rdata_nxt;
         lat_r   <= lat_nxt;
         act_r   <= act_nxt;
         cnt_r   <= cnt_nxt;
         st_r    <= st_nxt;
         done_r  <= done_nxt;
         msk_r   <= msk_nxt;
         port_r  <= port_nxt;
         so_r    <= so_nxt;
         oe_r    <= oe_nxt;
         irq_r   <= irq_nxt;
         sck_d_r <= sck_s;
      end
   end

   assign rdata_o             = rdata_r;
   assign serial_out_pin_o    = so_r;
   assign serial_out_pin_oe_o = oe_r;
   assign irq_o               = irq_r;

   // Checks
   chk_disable_clears: assert property (@(posedge clock_i) disable iff (!rst_n)
      !cfg_r.en |-> !act_r && shift_r == 8'h00)
      else $error("disable left transfer state");
   chk_done_ends: assert property (@(posedge clock_i) disable iff (!rst_n)
      $rose(done_r) |-> $fell(act_r))
      else $error("done flag without active end");
   chk_start_active: assert property (@(posedge clock_i) disable iff (!rst_n)
      start |=> act_r || !cfg_r.en)
      else $error("start did not set active");
   chk_mode0_low: assert property (@(posedge clock_i) disable iff (!rst_n)
      cfg_r.en && !cfg_r.trmd && !port_r[CSP_PORT_LAT_BIT]
      |=> !so_r || !cfg_r.en || cfg_r.trmd || port_r[CSP_PORT_LAT_BIT])
      else $error("receive mode output not low");
   chk_count_eight: assert property (@(posedge clock_i) disable iff (!rst_n)
      act_r |-> cnt_r < CSP_BITS)
      else $error("bit count beyond eight");
   chk_dis_endbit: assert property (@(posedge clock_i) disable iff (!rst_n)
      !cfg_r.en && cfg_r.trmd && cfg_r.dap && !port_r[0]
      |=> so_r == end_bit(txbuf_r, cfg_r.dir) || $changed(cfg_r) || $changed(txbuf_r)
          || $changed(port_r))
      else $error("disabled phase 1 output wrong");
   chk_phase1_first: assert property (@(posedge clock_i) disable iff (!rst_n)
      start && cfg_r.dap |=> lat_r == end_bit(txbuf_r, cfg_r.dir))
      else $error("phase 1 first bit not presented");
   chk_hold_last: assert property (@(posedge clock_i) disable iff (!rst_n)
      st_r == CSP_IDLE && !start && cfg_r.en && !wr_mode |=> $stable(lat_r))
      else $error("output changed after transfer");
   chk_oe_dir: assert property (@(posedge clock_i) disable iff (!rst_n)
      1'b1 |=> oe_r == ~port_r[CSP_PORT_DIR_BIT])
      else $error("output enable does not follow direction");
endmodule : csp_top

// >>> bench/csp_partner.sv
// Purpose: Serial clock master model facing the port's serial pins
// Assumes: Half period 32 ns, 64 ns when slow_i is high; bit order from lsb_first_i
// Notes:   Clock stands at its idle level between frames
`timescale 1ns/1ps
module csp_partner (
   // Control
   input  wire logic       start_i,
   input  wire logic       ckp_i,
   input  wire logic       dap_i,
   input  wire logic       lsb_first_i,
   input  wire logic       slow_i,
   input  wire logic [7:0] tx_byte_i,
   // Pins
   input  wire logic       so_i,
   output logic            sclk_o,
   output logic            si_o,
   // Result
   output logic [7:0]      rx_byte_o,
   output logic            busy_o
);
   int  k;
   time h;
   initial begin
      sclk_o = 1'b0;
      si_o = 1'b0;
      rx_byte_o = 8'h00;
      busy_o = 1'b0;
   end
   always @(ckp_i) begin
      if (!busy_o) begin
         sclk_o = ckp_i;
      end
   end
   always @(posedge start_i) begin
      busy_o = 1'b1;
      h = slow_i ? 64 : 32;
      #3;
      for (k = 0; k < 8; k++) begin
         si_o = tx_byte_i[lsb_first_i ? k : 7 - k];
         if (dap_i) begin
            #(h);
         end else begin
            sclk_o = ~ckp_i;
            #(h);
         end
         rx_byte_o[lsb_first_i ? k : 7 - k] = so_i;
         sclk_o = ~sclk_o;
         #(h);
         sclk_o = ckp_i;
      end
      // Released data line must not keep its last bit
      si_o = ~si_o;
      busy_o = 1'b0;
   end
endmodule : csp_partner

// >>> bench/csp_top_test.sv
// Purpose: Self-checking bench for the clocked serial port
// Assumes: Partner model acts as serial clock master
// Notes:   Pin levels are checked after the synchroniser has settled
`timescale 1ns/1ps
module csp_top_test;
   import csp_pkg::*;
   logic            clock_r;
   logic            rst_n_r;
   csp_bus_req_type bus_r;
   logic [7:0]      rdata;
   logic            sclk, si, so, so_oe, irq;
   logic            p_start, p_ckp, p_dap, p_lsb, p_slow, p_busy;
   logic [7:0]      p_tx, p_rx;
   int              miscompares = 0;
   int              comparisons = 0;
   int              cycles = 0;
   logic [7:0]      txv [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h69};
   logic [7:0]      rxv [4] = '{8'h81, 8'h7E, 8'h2D, 8'hB4};
   csp_top DUT (
      .clock_i            (clock_r),
      .rst_n_i            (rst_n_r),
      .bus_i              (bus_r),
      .rdata_o            (rdata),
      .serial_clock_pin_i (sclk),
      .serial_in_pin_i    (si),
      .serial_out_pin_o   (so),
      .serial_out_pin_oe_o(so_oe),
      .irq_o              (irq)
   );
   csp_partner PEER (
      .start_i    (p_start),
      .ckp_i      (p_ckp),
      .dap_i      (p_dap),
      .lsb_first_i(p_lsb),
      .slow_i     (p_slow),
      .tx_byte_i  (p_tx),
      .so_i       (so),
      .sclk_o     (sclk),
      .si_o       (si),
      .rx_byte_o  (p_rx),
      .busy_o     (p_busy)
   );
   always #4 clock_r = ~clock_r;
   task automatic complete_run;
      if (miscompares == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   always @(posedge clock_r) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares = miscompares + 1;
         complete_run();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus_r <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_r);
      bus_r <= '0;
      @(posedge clock_r);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      bus_r <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock_r);
      bus_r <= '0;
      #1;
      d = rdata;
      @(posedge clock_r);
   endtask : rd
   task automatic settle;
      repeat (4) @(posedge clock_r);
      #1;
   endtask : settle
   task automatic t_reset;
      logic [7:0] v;
      #1;
      check({6'h00, so, so_oe}, 8'h03);
      check({7'h00, irq}, 8'h00);
      rd(CSP_ADDR_MODE, v);
      check(v, 8'h00);
      rd(CSP_ADDR_CLKSEL, v);
      check(v, 8'h00);
      rd(CSP_ADDR_PORT, v);
      check(v, 8'h01);
   endtask : t_reset
   task automatic t_levels;
      wr(CSP_ADDR_PORT, 8'h00);
      wr(CSP_ADDR_TXBUF, 8'h96);
      wr(CSP_ADDR_MODE, 8'h80);
      settle();
      check({7'h00, so}, 8'h00);
      wr(CSP_ADDR_PORT, 8'h01);
      settle();
      check({7'h00, so}, 8'h01);
      wr(CSP_ADDR_PORT, 8'h00);
      wr(CSP_ADDR_MODE, 8'h40);
      settle();
      check({7'h00, so}, 8'h00);
      wr(CSP_ADDR_CLKSEL, 8'h08);
      settle();
      check({7'h00, so}, 8'h01);
      wr(CSP_ADDR_PORT, 8'h02);
      settle();
      check({7'h00, so_oe}, 8'h00);
      wr(CSP_ADDR_PORT, 8'h00);
      wr(CSP_ADDR_MODE, 8'h50);
      settle();
      check({7'h00, so}, 8'h00);
   endtask : t_levels
   task automatic frame(input logic ckp, dap, dir, trmd, slow, input logic [7:0] d, r);
      logic [7:0] v;
      int         n;
      wr(CSP_ADDR_MODE, 8'h00);
      p_ckp <= ckp;
      p_dap <= dap;
      p_lsb <= dir;
      p_slow <= slow;
      p_tx <= r;
      wr(CSP_ADDR_CLKSEL, {3'h0, ckp, dap, 3'h0});
      wr(CSP_ADDR_MODE, {1'b1, trmd, 1'b0, dir, 4'h0});
      if (trmd) wr(CSP_ADDR_TXBUF, d);
      else rd(CSP_ADDR_SHIFT, v);
      rd(CSP_ADDR_MODE, v);
      check({7'h00, v[0]}, 8'h01);
      if (dap && trmd) check({7'h00, so}, {7'h00, dir ? d[0] : d[7]});
      p_start <= 1'b1;
      @(posedge clock_r);
      p_start <= 1'b0;
      for (n = 0; n < 400 && p_busy; n++) @(posedge clock_r);
      check({7'h00, p_busy}, 8'h00);
      settle();
      check(p_rx, trmd ? d : 8'h00);
      check({7'h00, so}, {7'h00, trmd & (dir ? d[7] : d[0])});
      rd(CSP_ADDR_MODE, v);
      check({7'h00, v[0]}, 8'h00);
      rd(CSP_ADDR_SHIFT, v);
      check(v, r);
   endtask : frame
   task automatic t_irq;
      logic [7:0] v;
      wr(CSP_ADDR_IRQMSK, 8'h00);
      settle();
      check({7'h00, irq}, 8'h00);
      wr(CSP_ADDR_IRQMSK, 8'h01);
      settle();
      check({7'h00, irq}, 8'h01);
      rd(CSP_ADDR_IRQST, v);
      check(v, 8'h01);
      settle();
      check({7'h00, irq}, 8'h00);
      rd(CSP_ADDR_IRQST, v);
      check(v, 8'h00);
   endtask : t_irq
   task automatic t_abort;
      logic [7:0] v;
      wr(CSP_ADDR_MODE, 8'h00);
      wr(CSP_ADDR_MODE, 8'hC0);
      wr(CSP_ADDR_TXBUF, 8'h5A);
      rd(CSP_ADDR_MODE, v);
      check({7'h00, v[0]}, 8'h01);
      wr(CSP_ADDR_MODE, 8'h00);
      rd(CSP_ADDR_MODE, v);
      check(v, 8'h00);
      rd(CSP_ADDR_SHIFT, v);
      check(v, 8'h00);
   endtask : t_abort
   initial begin
      clock_r = 1'b0;
      rst_n_r = 1'b0;
      bus_r = '0;
      p_start = 1'b0;
      p_ckp = 1'b0;
      p_dap = 1'b0;
      p_lsb = 1'b0;
      p_slow = 1'b0;
      p_tx = 8'h00;
      repeat (12) @(posedge clock_r);
      rst_n_r <= 1'b1;
      repeat (3) @(posedge clock_r);
      t_reset();
      t_levels();
      for (int i = 0; i < 4; i++) frame(i[1], i[0], i == 3, 1'b1, i == 2, txv[i], rxv[i]);
      frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h5B);
      t_irq();
      t_abort();
      complete_run();
   end
endmodule : csp_top_test
